// file: design/lpcc_top.sv
// Purpose: low power clock controller: sources, system clock switch, prescalers, rtc, clock out
// Assumes: oscillator activity is modelled by tick inputs, one per oscillator, on clk
// Notes: derived clocks are one-cycle enable ticks on clk
//
// Contract
// - multispeed rc with seven doubling ranges
// - fast and slow internal rc, enable plus ready
// - slow external bits in control/status register
// - slow external enable bit 8, ready 9
// - pll enable/ready, source fast internal or external
// - pll output divider field of its own
// - four system sources, select plus status
// - reset on multispeed 2 MHz, max 32 MHz
// - core and two peripheral bus prescalers
// - rtc from slow int, slow ext, fast ext/n
// - rtc select at control/status bits 17:16
// - rtc enable at control/status bit 22
// - fast external rtc divider in control register
// - clock output source of seven, prescale 1..16
// - clock output prescaler and select separate fields
// - slow oscillators to timer a, fast ext/msi timer b
// - security and six ready interrupts, enable/clear
module lpcc_top #(
   parameter int FAST_SETTLE = lpcc_pkg::SETTLE_FAST_CYC,
   parameter int SLOW_SETTLE = lpcc_pkg::SETTLE_SLOW_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   // oscillator activity ticks
   input wire logic multispeed_rc_osc,
   input wire logic fast_internal_osc,
   input wire logic slow_internal_osc,
   input wire logic fast_external_osc,
   input wire logic slow_external_osc,
   input wire logic pll_osc,
   input wire logic fast_external_fail,
   // clock control fields
   input wire logic multispeed_osc_enable,
   input wire logic [2:0] multispeed_range,
   input wire logic fast_internal_enable,
   input wire logic fast_external_enable,
   input wire logic pll_enable_bit,
   input wire logic css_enable,
   input wire logic [1:0] rtc_fast_ext_divider,
   // clock config fields
   input wire logic [1:0] system_clock_source_select,
   input wire logic pll_source_fast_ext,
   input wire logic [3:0] pll_multiplier,
   input wire logic [1:0] pll_output_divider,
   input wire logic [3:0] core_bus_prescaler,
   input wire logic [2:0] periph_bus_a_prescaler,
   input wire logic [2:0] periph_bus_b_prescaler,
   input wire logic [2:0] clock_output_select,
   input wire logic [2:0] clock_output_prescaler,
   // control/status register image in
   input wire logic [31:0] control_status_wr,
   // interrupt enable and clear
   input wire logic [lpcc_pkg::IRQ_N-1:0] ready_irq_enable,
   input wire logic [lpcc_pkg::IRQ_N-1:0] ready_irq_clear,
   input wire logic css_irq_clear,
   // status out
   output logic multispeed_osc_ready,
   output logic fast_internal_ready,
   output logic fast_external_ready,
   output logic pll_ready_flag,
   output logic [31:0] control_status_rd,
   output logic [1:0] system_clock_source_status,
   output logic [2:0] multispeed_range_status,
   output logic [3:0] pll_multiplier_status,
   output logic [lpcc_pkg::IRQ_N-1:0] ready_irq_pending,
   output logic css_irq_pending,
   output logic clock_irq,
   output logic css_irq,
   // derived clock ticks
   output logic system_clock,
   output logic core_bus_clock,
   output logic periph_bus_a_clock,
   output logic periph_bus_b_clock,
   output logic rtc_clock,
   output logic clock_output_pin,
   output logic timer_a_capture,
   output logic timer_b_capture
);
   // ------------------------------------------------------------
   // control/status register fields
   // ------------------------------------------------------------
   logic slow_internal_enable;
   logic slow_external_enable;
   logic [1:0] rtc_source_select;
   logic rtc_clock_enable;
   logic slow_internal_ready;
   logic slow_external_ready;

   // slow external bits live here, not in a backup-domain register
   assign slow_internal_enable = control_status_wr[lpcc_pkg::CSR_SLOW_INT_EN_BIT];
   assign slow_external_enable = control_status_wr[lpcc_pkg::CSR_SLOW_EXT_EN_BIT];
   assign rtc_source_select =
      control_status_wr[lpcc_pkg::CSR_RTC_SEL_MSB:lpcc_pkg::CSR_RTC_SEL_LSB];
   assign rtc_clock_enable = control_status_wr[lpcc_pkg::CSR_RTC_EN_BIT];

   // ------------------------------------------------------------
   // ready trackers
   // ------------------------------------------------------------
   logic [lpcc_pkg::IRQ_N-1:0] rdy;
   logic [lpcc_pkg::IRQ_N-1:0] rdy_rise;
   logic [lpcc_pkg::IRQ_N-1:0] osc_en;
   logic pll_src_ok;

   // pll may only run from the fast internal or fast external source
   assign pll_src_ok = pll_source_fast_ext ? rdy[2] : rdy[1];
   assign osc_en = {slow_external_enable, slow_internal_enable, pll_enable_bit & pll_src_ok,
                    fast_external_enable, fast_internal_enable, multispeed_osc_enable};

   lpcc_osc_ready #(.SETTLE(FAST_SETTLE)) u_rdy_msi (
      .clk(clk), .sys_rst(sys_rst), .enable(osc_en[0]), .ready(rdy[0]),
      .ready_rise(rdy_rise[0]));
   lpcc_osc_ready #(.SETTLE(FAST_SETTLE)) u_rdy_fint (
      .clk(clk), .sys_rst(sys_rst), .enable(osc_en[1]), .ready(rdy[1]),
      .ready_rise(rdy_rise[1]));
   lpcc_osc_ready #(.SETTLE(FAST_SETTLE)) u_rdy_fext (
      .clk(clk), .sys_rst(sys_rst), .enable(osc_en[2]), .ready(rdy[2]),
      .ready_rise(rdy_rise[2]));
   lpcc_osc_ready #(.SETTLE(FAST_SETTLE)) u_rdy_pll (
      .clk(clk), .sys_rst(sys_rst), .enable(osc_en[3]), .ready(rdy[3]),
      .ready_rise(rdy_rise[3]));
   lpcc_osc_ready #(.SETTLE(SLOW_SETTLE)) u_rdy_sint (
      .clk(clk), .sys_rst(sys_rst), .enable(osc_en[4]), .ready(rdy[4]),
      .ready_rise(rdy_rise[4]));
   lpcc_osc_ready #(.SETTLE(SLOW_SETTLE)) u_rdy_sext (
      .clk(clk), .sys_rst(sys_rst), .enable(osc_en[5]), .ready(rdy[5]),
      .ready_rise(rdy_rise[5]));

   assign slow_internal_ready = rdy[4];
   assign slow_external_ready = rdy[5];

   // ------------------------------------------------------------
   // registered status outputs
   // ------------------------------------------------------------
   // msi range and pll factor are latched so status never shows a torn value
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         multispeed_osc_ready <= 1'b0;
         fast_internal_ready <= 1'b0;
         fast_external_ready <= 1'b0;
         pll_ready_flag <= 1'b0;
         control_status_rd <= '0;
         multispeed_range_status <= lpcc_pkg::MSI_RANGE_RESET;
         pll_multiplier_status <= '0;
      end else begin
         multispeed_osc_ready <= rdy[0];
         fast_internal_ready <= rdy[1];
         fast_external_ready <= rdy[2];
         pll_ready_flag <= rdy[3];
         control_status_rd <= control_status_wr;
         control_status_rd[lpcc_pkg::CSR_SLOW_INT_RDY_BIT] <= slow_internal_ready;
         control_status_rd[lpcc_pkg::CSR_SLOW_EXT_RDY_BIT] <= slow_external_ready;
         if (multispeed_range < lpcc_pkg::MSI_RANGES) begin
            multispeed_range_status <= multispeed_range;
         end
         if (!pll_enable_bit) begin
            pll_multiplier_status <= pll_multiplier;
         end
      end
   end

   // ------------------------------------------------------------
   // system clock switch
   // ------------------------------------------------------------
   lpcc_pkg::lpcc_sw_state_t sw_state;
   logic [1:0] sys_src;
   logic [1:0] sw_target;
   logic [1:0] sw_gap;
   logic target_ready;

   assign target_ready = rdy[system_clock_source_select];

   // hold the old source until the new one is ready, then a short dead gap
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sw_state <= lpcc_pkg::LPCC_SW_IDLE;
         sys_src <= lpcc_pkg::LPCC_SYS_MSI;
         sw_target <= lpcc_pkg::LPCC_SYS_MSI;
         sw_gap <= '0;
      end else begin
         case (sw_state)
            lpcc_pkg::LPCC_SW_IDLE: begin
               if (system_clock_source_select != sys_src) begin
                  sw_state <= lpcc_pkg::LPCC_SW_WAIT;
               end
            end
            lpcc_pkg::LPCC_SW_WAIT: begin
               if (system_clock_source_select == sys_src) begin
                  sw_state <= lpcc_pkg::LPCC_SW_IDLE;
               end else if (target_ready) begin
                  sw_target <= system_clock_source_select;
                  sw_gap <= '0;
                  sw_state <= lpcc_pkg::LPCC_SW_GAP;
               end
            end
            lpcc_pkg::LPCC_SW_GAP: begin
               if (sw_gap == 2'(lpcc_pkg::SW_GAP_CYC - 1)) begin
                  sys_src <= sw_target;
                  sw_state <= lpcc_pkg::LPCC_SW_IDLE;
               end else begin
                  sw_gap <= sw_gap + 1'b1;
               end
            end
            default: sw_state <= lpcc_pkg::LPCC_SW_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // source ticks
   // ------------------------------------------------------------
   logic sys_tick;
   logic pll_tick;
   logic pll_div_tick;
   logic [2:0] pll_div_cnt;
   logic rtc_fext_tick;
   logic rtc_sel_tick;

   // pll output divides by 2, 3 or 4 with code 0 reserved as off
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pll_div_cnt <= '0;
         pll_div_tick <= 1'b0;
      end else begin
         pll_div_tick <= 1'b0;
         if (pll_osc && rdy[3] && pll_output_divider != 2'h0) begin
            if (pll_div_cnt >= 3'(pll_output_divider)) begin
               pll_div_cnt <= '0;
               pll_div_tick <= 1'b1;
            end else begin
               pll_div_cnt <= pll_div_cnt + 1'b1;
            end
         end
      end
   end
   assign pll_tick = pll_div_tick;

   // gapped during the switch so no short pulse reaches the core
   always_comb begin
      sys_tick = 1'b0;
      if (sw_state != lpcc_pkg::LPCC_SW_GAP) begin
         case (sys_src)
            lpcc_pkg::LPCC_SYS_MSI: sys_tick = multispeed_rc_osc;
            lpcc_pkg::LPCC_SYS_FAST_INT: sys_tick = fast_internal_osc;
            lpcc_pkg::LPCC_SYS_FAST_EXT: sys_tick = fast_external_osc;
            lpcc_pkg::LPCC_SYS_PLL: sys_tick = pll_tick;
            default: sys_tick = 1'b0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // bus prescalers
   // ------------------------------------------------------------
   logic core_tick;
   logic pa_tick;
   logic pb_tick;

   // above 32 MHz is a software fault; the divider does not police it
   lpcc_divider #(.W(15)) u_core (.clk(clk), .sys_rst(sys_rst), .tick_in(sys_tick),
      .shift(core_bus_prescaler), .tick_out(core_tick));
   lpcc_divider #(.W(7)) u_pa (.clk(clk), .sys_rst(sys_rst), .tick_in(core_tick),
      .shift({1'b0, periph_bus_a_prescaler}), .tick_out(pa_tick));
   lpcc_divider #(.W(7)) u_pb (.clk(clk), .sys_rst(sys_rst), .tick_in(core_tick),
      .shift({1'b0, periph_bus_b_prescaler}), .tick_out(pb_tick));

   // ------------------------------------------------------------
   // rtc source
   // ------------------------------------------------------------
   // divider codes 0..3 give /2, /4, /8, /16
   lpcc_divider #(.W(4)) u_rtc (.clk(clk), .sys_rst(sys_rst), .tick_in(fast_external_osc),
      .shift({2'h0, rtc_fast_ext_divider} + 4'h1), .tick_out(rtc_fext_tick));

   always_comb begin
      case (rtc_source_select)
         lpcc_pkg::LPCC_RTC_SLOW_EXT: rtc_sel_tick = slow_external_osc;
         lpcc_pkg::LPCC_RTC_SLOW_INT: rtc_sel_tick = slow_internal_osc;
         lpcc_pkg::LPCC_RTC_FAST_EXT: rtc_sel_tick = rtc_fext_tick;
         default: rtc_sel_tick = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // clock output
   // ------------------------------------------------------------
   logic mco_sel_tick;
   logic mco_tick;

   always_comb begin
      case (clock_output_select)
         lpcc_pkg::LPCC_MCO_SYS: mco_sel_tick = sys_tick;
         lpcc_pkg::LPCC_MCO_FAST_INT: mco_sel_tick = fast_internal_osc;
         lpcc_pkg::LPCC_MCO_MSI: mco_sel_tick = multispeed_rc_osc;
         lpcc_pkg::LPCC_MCO_FAST_EXT: mco_sel_tick = fast_external_osc;
         lpcc_pkg::LPCC_MCO_PLL: mco_sel_tick = pll_tick;
         lpcc_pkg::LPCC_MCO_SLOW_INT: mco_sel_tick = slow_internal_osc;
         lpcc_pkg::LPCC_MCO_SLOW_EXT: mco_sel_tick = slow_external_osc;
         default: mco_sel_tick = 1'b0;
      endcase
   end

   // codes above 4 clamp to divide by 16
   lpcc_divider #(.W(4)) u_mco (.clk(clk), .sys_rst(sys_rst), .tick_in(mco_sel_tick),
      .shift((clock_output_prescaler > 3'h4) ? 4'h4 : {1'b0, clock_output_prescaler}),
      .tick_out(mco_tick));

   // ------------------------------------------------------------
   // registered tick outputs and timer routing
   // ------------------------------------------------------------
   // routing to timers needs no configuration
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         system_clock <= 1'b0;
         core_bus_clock <= 1'b0;
         periph_bus_a_clock <= 1'b0;
         periph_bus_b_clock <= 1'b0;
         rtc_clock <= 1'b0;
         clock_output_pin <= 1'b0;
         timer_a_capture <= 1'b0;
         timer_b_capture <= 1'b0;
         system_clock_source_status <= lpcc_pkg::LPCC_SYS_MSI;
      end else begin
         system_clock <= sys_tick;
         core_bus_clock <= core_tick;
         periph_bus_a_clock <= pa_tick;
         periph_bus_b_clock <= pb_tick;
         rtc_clock <= rtc_clock_enable & rtc_sel_tick;
         clock_output_pin <= mco_tick;
         timer_a_capture <= slow_internal_osc | slow_external_osc;
         timer_b_capture <= fast_external_osc | multispeed_rc_osc;
         system_clock_source_status <= sys_src;
      end
   end

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   // set wins over clear so no ready event is lost
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ready_irq_pending <= '0;
         css_irq_pending <= 1'b0;
         clock_irq <= 1'b0;
         css_irq <= 1'b0;
      end else begin
         ready_irq_pending <= (ready_irq_pending & ~ready_irq_clear)
            | (rdy_rise & ready_irq_enable);
         css_irq_pending <= (css_irq_pending & ~css_irq_clear)
            | (css_enable & rdy[2] & fast_external_fail);
         clock_irq <= |ready_irq_pending;
         css_irq <= css_irq_pending;
      end
   end
endmodule : lpcc_top

// file: design/lpcc_pkg.sv
// Purpose: shared constants for the low power clock controller
// Assumes: one 20 MHz system clock, oscillators modelled as enables and ready handshakes
// Notes: control and status bits are plain ports, field codes live here
package lpcc_pkg;
   // ------------------------------------------------------------
   // clocking and stabilisation
   // ------------------------------------------------------------
   localparam int CLK_HZ = 20000000;
   localparam int SETTLE_FAST_NS = 2000;   // fast oscillators and pll
   localparam int SETTLE_SLOW_NS = 20000;  // slow crystals and rc
   localparam int SETTLE_FAST_CYC = (SETTLE_FAST_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int SETTLE_SLOW_CYC = (SETTLE_SLOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int CNT_W = 16;

   // ------------------------------------------------------------
   // oscillator frequencies in hz
   // ------------------------------------------------------------
   localparam int MSI_MIN_HZ = 64000;
   localparam int MSI_MAX_HZ = 4100000;
   localparam int FAST_INT_HZ = 16000000;
   localparam int SLOW_INT_HZ = 37000;
   localparam int SYSTEM_CLOCK_MAX_HZ = 32000000;
   localparam logic [2:0] MSI_RANGES = 3'h7;
   localparam logic [2:0] MSI_RANGE_RESET = 3'h5;  // 2 MHz after reset

   // ------------------------------------------------------------
   // control/status field positions
   // ------------------------------------------------------------
   localparam int CSR_SLOW_EXT_EN_BIT = 8;
   localparam int CSR_SLOW_EXT_RDY_BIT = 9;
   localparam int CSR_RTC_SEL_LSB = 16;
   localparam int CSR_RTC_SEL_MSB = 17;
   localparam int CSR_RTC_EN_BIT = 22;
   localparam int CSR_SLOW_INT_EN_BIT = 0;
   localparam int CSR_SLOW_INT_RDY_BIT = 1;

   // ------------------------------------------------------------
   // enumerations
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      LPCC_SYS_MSI = 2'h0,
      LPCC_SYS_FAST_INT = 2'h1,
      LPCC_SYS_FAST_EXT = 2'h2,
      LPCC_SYS_PLL = 2'h3
   } lpcc_sys_src_t;

   typedef enum logic [1:0] {
      LPCC_RTC_NONE = 2'h0,
      LPCC_RTC_SLOW_EXT = 2'h1,
      LPCC_RTC_SLOW_INT = 2'h2,
      LPCC_RTC_FAST_EXT = 2'h3
   } lpcc_rtc_src_t;

   typedef enum logic [2:0] {
      LPCC_MCO_OFF = 3'h0,
      LPCC_MCO_SYS = 3'h1,
      LPCC_MCO_FAST_INT = 3'h2,
      LPCC_MCO_MSI = 3'h3,
      LPCC_MCO_FAST_EXT = 3'h4,
      LPCC_MCO_PLL = 3'h5,
      LPCC_MCO_SLOW_INT = 3'h6,
      LPCC_MCO_SLOW_EXT = 3'h7
   } lpcc_mco_src_t;

   typedef enum logic [1:0] {
      LPCC_SW_IDLE = 2'h0,
      LPCC_SW_WAIT = 2'h1,
      LPCC_SW_GAP = 2'h2
   } lpcc_sw_state_t;

   localparam int SW_GAP_CYC = 2;  // dead cycles while switching
   localparam int PSC_W = 4;
   localparam int IRQ_N = 6;       // msi, fast int, fast ext, pll, slow int, slow ext
endpackage : lpcc_pkg

// file: design/lpcc_osc_ready.sv
// Purpose: ready tracker for one oscillator
// Assumes: enable is a level; ready falls on the cycle after disable
// Notes: one instance per clock source
module lpcc_osc_ready #(
   parameter int SETTLE = 40
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic enable,
   output logic ready,
   output logic ready_rise
);
   logic [lpcc_pkg::CNT_W-1:0] count;

   // ------------------------------------------------------------
   // settle counter
   // ------------------------------------------------------------
   // ready only after a full settle window of continuous enable
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= '0;
         ready <= 1'b0;
         ready_rise <= 1'b0;
      end else begin
         ready_rise <= 1'b0;
         if (!enable) begin
            count <= '0;
            ready <= 1'b0;
         end else if (!ready) begin
            if (count == lpcc_pkg::CNT_W'(SETTLE - 1)) begin
               ready <= 1'b1;
               ready_rise <= 1'b1;
            end else begin
               count <= count + 1'b1;
            end
         end
      end
   end
endmodule : lpcc_osc_ready

// file: design/lpcc_divider.sv
// Purpose: power-of-two enable divider
// Assumes: shift code 0 means divide by 1
// Notes: emits a one-cycle tick each divided period
module lpcc_divider #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic tick_in,
   input wire logic [3:0] shift,
   output logic tick_out
);
   logic [W-1:0] count;
   logic [W-1:0] limit;

   assign limit = W'((32'h1 << shift) - 1);

   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   // counting input ticks keeps everything on the one clock
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= '0;
         tick_out <= 1'b0;
      end else begin
         tick_out <= 1'b0;
         if (tick_in) begin
            if (count >= limit) begin
               count <= '0;
               tick_out <= 1'b1;
            end else begin
               count <= count + 1'b1;
            end
         end
      end
   end
endmodule : lpcc_divider

// file: verif/lpcc_chk_sva.sv
// Purpose: port assertions for the clock controller
// Assumes: ready irq bit 1 is the fast internal source
// Notes: bound onto lpcc_top below the module
module lpcc_chk #(
   parameter int FAST_SETTLE = 4,
   parameter int SLOW_SETTLE = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic fast_internal_enable,
   input wire logic fast_internal_ready,
   input wire logic [1:0] system_clock_source_select,
   input wire logic [1:0] system_clock_source_status,
   input wire logic [31:0] control_status_wr,
   input wire logic [31:0] control_status_rd,
   input wire logic [lpcc_pkg::IRQ_N-1:0] ready_irq_pending,
   input wire logic [lpcc_pkg::IRQ_N-1:0] ready_irq_clear,
   input wire logic clock_irq,
   input wire logic rtc_clock
);
   // ------------------------------------------------------------
   // assertions, all on clk
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // the first edge after reset sees reset-time values, hence the guards
   chk_ready_settle: assert property ($rose(fast_internal_ready) |->
      $past(fast_internal_enable, FAST_SETTLE)) else $error("fast ready rose early");
   chk_ready_drop: assert property ($fell(fast_internal_enable) |->
      ##[0:2] !fast_internal_ready) else $error("fast ready stayed up");
   chk_rtc_field: assert property (!$past(sys_rst) |->
      control_status_rd[22:16] == $past(control_status_wr[22:16])) else $error("rtc field");
   chk_slow_ext_en: assert property (!$past(sys_rst) |->
      control_status_rd[8] == $past(control_status_wr[8])) else $error("slow ext enable");
   chk_sw_ready: assert property ($changed(system_clock_source_status) &&
      system_clock_source_status == 2'h1 |-> $past(fast_internal_ready, 2)) else $error("early switch");
   chk_sw_match: assert property ($changed(system_clock_source_status) |->
      system_clock_source_status == $past(system_clock_source_select, 4)) else $error("status not select");
   chk_sw_bound: assert property ($changed(system_clock_source_select) && fast_internal_ready &&
      system_clock_source_select == 2'h1 |-> ##[2:6] system_clock_source_status == 2'h1) else $error("slow");
   chk_irq_follow: assert property (!$past(sys_rst) |->
      clock_irq == (|$past(ready_irq_pending))) else $error("clock irq wrong");
   chk_pend_hold: assert property (ready_irq_pending[1] && !ready_irq_clear[1] |=>
      ready_irq_pending[1]) else $error("pending lost");
   chk_rtc_gate: assert property (rtc_clock |->
      $past(control_status_wr[22]) || $past(control_status_wr[22], 2)) else $error("rtc gated");
endmodule : lpcc_chk

bind lpcc_top lpcc_chk #(.FAST_SETTLE(FAST_SETTLE), .SLOW_SETTLE(SLOW_SETTLE)) i_chk (
   .clk, .sys_rst, .fast_internal_enable, .fast_internal_ready, .system_clock_source_select,
   .system_clock_source_status, .control_status_wr, .control_status_rd, .ready_irq_pending,
   .ready_irq_clear, .clock_irq, .rtc_clock);

// file: verif/tb_top.sv
// Purpose: directed bench for the clock controller
// Assumes: inputs move on the falling edge, settle counts cut to 4 and 8
// Notes: each scenario task drives and judges by itself
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------
   logic clk = 1'h0, sys_rst = 1'h1, multispeed_rc_osc = 1'h0, fast_internal_osc = 1'h0;
   logic slow_internal_osc = 1'h0, fast_external_osc = 1'h0, slow_external_osc = 1'h0;
   logic pll_osc = 1'h0, fast_external_fail = 1'h0, multispeed_osc_enable = 1'h0;
   logic fast_internal_enable = 1'h0, fast_external_enable = 1'h0, pll_enable_bit = 1'h0;
   logic css_enable = 1'h0, pll_source_fast_ext = 1'h0, css_irq_clear = 1'h0;
   logic [1:0] rtc_fast_ext_divider = 2'h0, system_clock_source_select = 2'h0;
   logic [1:0] pll_output_divider = 2'h0, system_clock_source_status;
   logic [2:0] multispeed_range = 3'h5, periph_bus_a_prescaler = 3'h0;
   logic [2:0] periph_bus_b_prescaler = 3'h0, clock_output_select = 3'h0;
   logic [2:0] clock_output_prescaler = 3'h0, multispeed_range_status;
   logic [3:0] pll_multiplier = 4'h0, core_bus_prescaler = 4'h0, pll_multiplier_status;
   logic [31:0] control_status_wr = 32'h0, control_status_rd;
   logic [lpcc_pkg::IRQ_N-1:0] ready_irq_enable = 6'h0, ready_irq_clear = 6'h0;
   logic [lpcc_pkg::IRQ_N-1:0] ready_irq_pending;
   logic multispeed_osc_ready, fast_internal_ready, fast_external_ready, pll_ready_flag;
   logic css_irq_pending, clock_irq, css_irq, system_clock, core_bus_clock, rtc_clock;
   logic periph_bus_a_clock, periph_bus_b_clock, clock_output_pin;
   logic timer_a_capture, timer_b_capture;
   int fail_count = 0, samples_checked = 0, n, a, b;

   lpcc_top #(.FAST_SETTLE(4), .SLOW_SETTLE(8)) i_dut (.*);
   always #25 clk = ~clk;

   // ------------------------------------------------------------
   // shared helpers
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // a wait that ran out ends the run, nothing after it is meaningful
   task automatic bound(input int lim);
      check(32'(n < lim), 32'h1);
      if (n >= lim) end_of_test();
   endtask : bound
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   // pulse one oscillator tick and count what comes out over five cycles
   task automatic pulse(input logic slow_int, input logic slow_ext, input logic fast_ext);
      {slow_internal_osc, slow_external_osc, fast_external_osc} = {slow_int, slow_ext, fast_ext};
      @(negedge clk);
      {slow_internal_osc, slow_external_osc, fast_external_osc} = 3'h0;
      a = 0;
      b = 0;
      repeat (5) begin
         a += rtc_clock + system_clock;
         b += timer_a_capture + core_bus_clock;
         @(negedge clk);
      end
   endtask : pulse

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_fast_int();
      check(32'(system_clock_source_status), 32'h0);
      check(32'(multispeed_range_status), 32'h5);
      ready_irq_enable = 6'h02;
      fast_internal_enable = 1'h1;
      for (n = 0; n < 40 && fast_internal_ready !== 1'h1; n++) @(negedge clk);
      bound(40);
      check(32'(n), 32'h5);
      repeat (3) @(negedge clk);
      check(32'(ready_irq_pending), 32'h02);
      check(32'(clock_irq), 32'h1);
      ready_irq_clear = 6'h02;
      @(negedge clk);
      ready_irq_clear = 6'h00;
      repeat (2) @(negedge clk);
      check(32'(clock_irq), 32'h0);
   endtask : t_fast_int
   // switch to fast internal, then ask for an external source that is still off
   task automatic t_switch();
      system_clock_source_select = 2'h1;
      for (n = 0; n < 20 && system_clock_source_status !== 2'h1; n++) @(negedge clk);
      bound(20);
      check(32'(n), 32'h5);
      system_clock_source_select = 2'h2;
      repeat (30) @(negedge clk);
      check(32'(system_clock_source_status), 32'h1);
      fast_external_enable = 1'h1;
      for (n = 0; n < 40 && system_clock_source_status !== 2'h2; n++) @(negedge clk);
      bound(40);
      pulse(1'h0, 1'h0, 1'h1);
      check(32'({a[15:0], b[15:0]}), 32'h1_0001);
   endtask : t_switch
   // rtc source table: only the selected slow tick reaches rtc, both reach timer a
   task automatic t_rtc();
      for (int i = 0; i < 5; i++) begin
         control_status_wr = {9'h0, i < 4, 4'h0, (i < 2) ? 2'h2 : 2'h1, 7'h0, 9'h101};
         for (n = 0; n < 40 && control_status_rd[9] !== 1'h1; n++) @(negedge clk);
         bound(40);
         pulse(i[0], !i[0], 1'h0);
         check(32'({a[15:0], b[15:0]}), {15'h0, i < 4 && (i < 2) == i[0], 16'h1});
      end
      check(32'(control_status_rd[22:0]), 32'h1_0303);
   endtask : t_rtc
   // fast external is still ready here, so a failure must reach the security irq
   task automatic t_disable();
      css_enable = 1'h1;
      fast_external_fail = 1'h1;
      control_status_wr[8] = 1'h0;
      fast_internal_enable = 1'h0;
      repeat (4) @(negedge clk);
      check(32'({control_status_rd[9:8], fast_internal_ready}), 32'h0);
      check(32'(css_irq), 32'h1);
   endtask : t_disable

   initial begin
      repeat (8) @(negedge clk);
      sys_rst = 1'h0;
      multispeed_osc_enable = 1'h1;
      @(negedge clk);
      t_fast_int();
      t_switch();
      t_rtc();
      t_disable();
      end_of_test();
   end
endmodule : tb_top
